// [odc_core.sv]
// serial command interpreter of an eight-channel 16-bit output converter
// pins come from outside the clock domain; register port is same-clock logic
`timescale 1ns/1ps

module odc_core
  import odc_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_resetn,
  input  wire logic                 i_clk_en,
  input  wire odc_pins_t            i_pins,
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [31:0]          i_reg_wdata,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  output logic      [31:0]          o_reg_rdata,
  output odc_chan_t [NCH-1:0]       o_chan,
  output logic                      o_clear_mode,
  output logic                      o_por_busy
);

  // pin synchronisers; idle levels high except clock and data
  localparam odc_pins_t PINS_IDLE = 5'h13;
  odc_pins_t s1_q;
  odc_pins_t s2_q;
  odc_pins_t prev_q;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s1_q   <= PINS_IDLE;
      s2_q   <= PINS_IDLE;
      prev_q <= PINS_IDLE;
    end
    else if (i_clk_en)
    begin
      s1_q   <= i_pins;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  logic sclk_fall;
  logic frame_fall;
  logic frame_rise;
  logic load_outputs_n_fall;
  logic clr_fall;
  logic load_outputs_n_low;
  assign sclk_fall  = prev_q.shift_clk & ~s2_q.shift_clk;
  assign frame_fall = prev_q.frame_n & ~s2_q.frame_n;
  assign frame_rise = ~prev_q.frame_n & s2_q.frame_n;
  assign load_outputs_n_low   = ~s2_q.load_outputs_n;
  // load and clear pin events count only once power-on reset is over
  assign load_outputs_n_fall  = prev_q.load_outputs_n & load_outputs_n_low & ~o_por_busy;
  assign clr_fall   = prev_q.async_clear_n & ~s2_q.async_clear_n & ~o_por_busy;

  // control state
  logic [POR_CW-1:0] por_cnt_q;
  logic              link_en_q;
  logic [1:0]        csel_q;
  logic [7:0]        ovr_q;
  logic              clear_mode_q;
  odc_state_t        state_q;
  logic [FW-1:0]     shreg_q;
  logic [4:0]        bit_cnt_q;

  logic [FW-1:0] word;
  logic          exec;
  logic          soft_rst;
  logic          clr_fire;
  logic [3:0]    w_cmd;
  logic [3:0]    w_addr;
  logic [15:0]   w_data;
  logic [1:0]    w_pd;
  logic [15:0]   clr_code;

  assign word   = {shreg_q[FW-2:0], s2_q.serial_data};
  assign w_cmd  = word[CMD_LSB +: 4];
  assign w_addr = word[ADDR_LSB +: 4];
  assign w_data = word[DATA_LSB +: CW];
  assign w_pd   = word[PD_LSB +: 2];
  // last bit and execution on the 32nd edge, unless a clear aborts it
  assign exec   = (state_q == ST_SHIFT) & sclk_fall & (bit_cnt_q == LAST_BIT)
                  & ~clr_fall;
  assign soft_rst = exec & (w_cmd == CMD_SW_RESET);
  assign clr_fire = clr_fall & (csel_q != CSEL_NOP);

  always_comb
  begin
    unique case (csel_q)
      CSEL_MID:  clr_code = CODE_MID;
      CSEL_FULL: clr_code = CODE_FULL;
      default:   clr_code = CODE_ZERO;
    endcase
  end

  assign o_por_busy = (por_cnt_q != '0);

  // power-on hold; a software reset runs it again
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      por_cnt_q <= POR_CW'(POR_CYCLES);
    else if (i_clk_en)
    begin
      if (soft_rst)
        por_cnt_q <= POR_CW'(POR_CYCLES);
      else if (o_por_busy)
        por_cnt_q <= por_cnt_q - 1'b1;
    end
  end

  // frame receiver
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q   <= ST_IDLE;
      shreg_q   <= '0;
      bit_cnt_q <= '0;
    end
    else if (i_clk_en)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (frame_fall & link_en_q & ~clr_fall)
          begin
            state_q   <= ST_SHIFT;
            shreg_q   <= '0;
            bit_cnt_q <= '0;
          end
        end
        ST_SHIFT:
        begin
          if (clr_fall | exec)
          begin
            state_q <= ST_IDLE;
            shreg_q <= '0;
          end
          else if (frame_rise)
          begin
            state_q <= ST_IDLE;
            shreg_q <= '0;
          end
          else if (sclk_fall)
          begin
            shreg_q   <= word;
            bit_cnt_q <= bit_cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // clear select, override mask and clear mode
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      csel_q       <= CSEL_RST;
      ovr_q        <= OVR_RST;
      clear_mode_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (soft_rst)
      begin
        csel_q       <= CSEL_RST;
        ovr_q        <= OVR_RST;
        clear_mode_q <= 1'b0;
      end
      else
      begin
        if (exec & (w_cmd == CMD_CLR_CODE))
          csel_q <= word[CSEL_LSB +: 2];
        if (exec & (w_cmd == CMD_OVERRIDE))
          ovr_q <= word[MASK_LSB +: NCH];
        // a clear arriving with a frame's end aborts it, so set wins
        if (clr_fire)
          clear_mode_q <= 1'b1;
        else if (exec)
          clear_mode_q <= 1'b0;
      end
    end
  end

  assign o_clear_mode = clear_mode_q;

  // per-channel input, dac and power registers
  logic [NCH-1:0][CW-1:0] in_all;
  logic [NCH-1:0][CW-1:0] dac_all;
  logic [NCH-1:0][1:0]    pd_all;

  for (genvar gi = 0; gi < NCH; gi++)
  begin : g_ch
    logic [CW-1:0] in_q;
    logic [CW-1:0] dac_q;
    logic [1:0]    pd_q;
    logic          sel;
    logic          upd;
    assign sel = (w_addr == 4'(gi)) | (w_addr == ADDR_ALL);
    assign upd = ovr_q[gi] | load_outputs_n_low;

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
      if (!i_resetn)
      begin
        in_q  <= CODE_RST;
        dac_q <= CODE_RST;
        pd_q  <= PD_NORMAL;
      end
      else if (i_clk_en)
      begin
        if (soft_rst)
        begin
          in_q  <= CODE_RST;
          dac_q <= CODE_RST;
          pd_q  <= PD_NORMAL;
        end
        else if (clr_fire)
        begin
          in_q  <= clr_code;
          dac_q <= clr_code;
        end
        else
        begin
          if (load_outputs_n_fall)
            dac_q <= in_q;
          if (exec)
          begin
            unique case (w_cmd)
              CMD_WR_IN:
                if (sel)
                begin
                  in_q <= w_data;
                  if (upd)
                    dac_q <= w_data;
                end
              CMD_UPD_DAC:
                if (sel)
                  dac_q <= in_q;
              CMD_WR_UPDALL:
                if (sel)
                begin
                  in_q  <= w_data;
                  dac_q <= w_data;
                end
                else
                  dac_q <= in_q;
              CMD_WR_UPD:
                if (sel)
                begin
                  in_q  <= w_data;
                  dac_q <= w_data;
                end
              CMD_PWR:
                if (word[MASK_LSB + gi])
                begin
                  // dac register is left alone by a power-down command
                  pd_q <= w_pd;
                  if ((w_pd == PD_NORMAL) & load_outputs_n_low)
                    dac_q <= in_q;
                end
              CMD_CLR_CODE, CMD_OVERRIDE, CMD_SW_RESET: ;
              default: ;
            endcase
          end
        end
      end
    end

    assign in_all[gi]  = in_q;
    assign dac_all[gi] = dac_q;
    assign pd_all[gi]  = pd_q;
    assign o_chan[gi]  = '{pd_mode: pd_q, code: dac_q};
  end

  // register port: link enable steers the receiver, the rest is readback
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      link_en_q <= LINK_EN_RST;
    else if (i_clk_en & i_reg_wr & (i_reg_addr == REG_CTRL))
      link_en_q <= i_reg_wdata[0];
  end

  logic [31:0] rd_mux;
  logic [2:0]  rd_idx;
  assign rd_idx = i_reg_addr[4:2];

  always_comb
  begin
    rd_mux = '0;
    if (i_reg_addr == REG_CTRL)
      rd_mux = {31'h0, link_en_q};
    else if (i_reg_addr == REG_STATUS)
      rd_mux = {27'h0, csel_q, state_q == ST_SHIFT, clear_mode_q, o_por_busy};
    else if (i_reg_addr == REG_OVR)
      rd_mux = {24'h0, ovr_q};
    else if (i_reg_addr == REG_PD)
      rd_mux = {16'h0, pd_all};
    else if ((i_reg_addr[7:5] == REG_DAC0[7:5]) & (i_reg_addr[1:0] == 2'h0))
      rd_mux = {16'h0, dac_all[rd_idx]};
    else if ((i_reg_addr[7:5] == REG_IN0[7:5]) & (i_reg_addr[1:0] == 2'h0))
      rd_mux = {16'h0, in_all[rd_idx]};
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      o_reg_rdata <= '0;
    else if (i_clk_en)
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0;
  end

endmodule

// [odc_core_bench.sv]
// self-checking bench of the serial command core
// host model sends frames; results read back over the register port and from the channel and clear mode outputs
`timescale 1ns/1ps

module odc_core_bench
  import odc_pkg::*;
;
  logic                clock;
  logic                resetn;
  logic                ld_n;
  logic                clr_n;
  logic                wr;
  logic                rd;
  logic [7:0]          addr;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  logic                frame_n;
  logic                sclk;
  logic                sdata;
  logic                clear_mode;
  logic                por_busy;
  odc_chan_t [NCH-1:0] chan;
  odc_pins_t           pins;
  int                  err_count;
  int                  samples_checked;
  logic [15:0]         clr_exp [4] = '{16'h0000, 16'h8000, 16'hffff, 16'h2222};

  assign pins = {frame_n, sclk, sdata, ld_n, clr_n};

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  odc_host host (.o_frame_n(frame_n), .o_shift_clk(sclk), .o_data(sdata));

  odc_core dut (
    .i_clock(clock), .i_resetn(resetn), .i_clk_en(1'b1), .i_pins(pins),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_chan(chan), .o_clear_mode(clear_mode), .o_por_busy(por_busy)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [19:0] low,
                       input int nbits = 32);
    host.send({4'h0, c, a, low}, nbits);
    repeat (8) @(posedge clock);
  endtask

  task automatic clear_pulse();
    @(posedge clock);
    clr_n <= 1'b0;
    repeat (6) @(posedge clock);
    clr_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    resetn = 1'b0;
    ld_n   = 1'b1;
    clr_n  = 1'b1;
    wr     = 1'b0;
    rd     = 1'b0;
    addr   = 8'h00;
    wdata  = 32'h0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    for (int n = 0; n < NCH; n++)
      rd_chk(REG_DAC0 + 8'(4 * n), 32'h0);
    rd_chk(REG_OVR, 32'h0);
    clear_pulse();
    rd_chk(REG_STATUS, 32'h1);
    for (int t = 0; t < 400 && por_busy !== 1'b0; t++)
      @(posedge clock);
    if (por_busy !== 1'b0)
    begin
      err_count++;
      $display("unexpected at %0t: hold never ended", $time);
      wrap_up();
    end
    $display("reset test done");
    frame(CMD_WR_UPD, 4'h2, 20'h12340);
    rd_chk(REG_DAC0 + 8'h08, 32'h1234);
    rd_chk(REG_DAC0 + 8'h04, 32'h0);
    frame(CMD_WR_IN, 4'h1, 20'habcd0);
    rd_chk(REG_IN0 + 8'h04, 32'habcd);
    rd_chk(REG_DAC0 + 8'h04, 32'h0);
    ld_n <= 1'b0;
    repeat (6) @(posedge clock);
    ld_n <= 1'b1;
    rd_chk(REG_DAC0 + 8'h04, 32'habcd);
    frame(CMD_WR_IN, 4'h0, 20'h43210);
    frame(CMD_UPD_DAC, 4'h0, 20'h0);
    rd_chk(REG_DAC0, 32'h4321);
    frame(CMD_WR_IN, 4'h4, 20'h77770);
    frame(CMD_WR_UPDALL, 4'h3, 20'h55550);
    rd_chk(REG_DAC0 + 8'h10, 32'h7777);
    rd_chk(REG_DAC0 + 8'h0c, 32'h5555);
    $display("command test done");
    frame(CMD_WR_UPD, 4'h5, 20'h99990, 20);
    rd_chk(REG_DAC0 + 8'h14, 32'h0);
    for (int c = 8; c < 16; c++)
      frame(4'(c), 4'h5, 20'h99990);
    rd_chk(REG_IN0 + 8'h14, 32'h0);
    wr_reg(REG_CTRL, 32'h0);
    frame(CMD_WR_UPD, 4'h5, 20'h11110);
    rd_chk(REG_DAC0 + 8'h14, 32'h0);
    wr_reg(REG_CTRL, 32'h1);
    rd_chk(8'hfc, 32'h0);
    $display("refusal test done");
    frame(CMD_WR_UPD, ADDR_ALL, 20'h22220);
    for (int n = 0; n < NCH; n++)
      rd_chk(REG_DAC0 + 8'(4 * n), 32'h2222);
    for (int m = 1; m < 4; m++)
    begin
      frame(CMD_PWR, 4'h0, {10'h0, 2'(m), 8'h81});
      rd_chk(REG_PD, {16'h0, 2'(m), 12'h0, 2'(m)});
      check(32'(chan[0].code), 32'h2222);
    end
    frame(CMD_PWR, 4'h0, 20'h000ff);
    rd_chk(REG_PD, 32'h0);
    rd_chk(REG_DAC0 + 8'h1c, 32'h2222);
    $display("power test done");
    for (int k = 0; k < 4; k++)
    begin
      frame(CMD_CLR_CODE, 4'h0, 20'((k + 3) % 4));
      rd_chk(REG_STATUS, 32'((k + 3) % 4) << 3);
      clear_pulse();
      rd_chk(REG_IN0 + 8'h18, 32'(clr_exp[(k + 3) % 4]));
      rd_chk(REG_DAC0, 32'(clr_exp[(k + 3) % 4]));
      check(32'(clear_mode), 32'((k + 3) % 4 != 3));
    end
    fork
      frame(CMD_WR_UPD, 4'h6, 20'h66660);
      begin
        repeat (300) @(posedge clock);
        clear_pulse();
      end
    join
    rd_chk(REG_DAC0 + 8'h18, 32'hffff);
    frame(CMD_OVERRIDE, 4'h0, 20'h000a5);
    check(32'(clear_mode), 32'h0);
    rd_chk(REG_OVR, 32'ha5);
    $display("clear test done");
    frame(CMD_SW_RESET, 4'h0, 20'h0);
    rd_chk(REG_STATUS, 32'h1);
    rd_chk(REG_OVR, 32'h0);
    for (int n = 0; n < NCH; n++)
      rd_chk(REG_DAC0 + 8'(4 * n), 32'h0);
    $display("software reset test done");
    wrap_up();
  end
endmodule

// [odc_core_props.sv]
// checks on the top ports of the serial command core
// bound to odc_core; clock enable held high by the bench
`timescale 1ns/1ps

module odc_core_props
  import odc_pkg::*;
(
  input wire logic                i_clock,
  input wire logic                i_resetn,
  input wire logic                i_clk_en,
  input wire odc_pins_t           i_pins,
  input wire logic [7:0]          i_reg_addr,
  input wire logic [31:0]         i_reg_wdata,
  input wire logic                i_reg_wr,
  input wire logic                i_reg_rd,
  input wire logic [31:0]         o_reg_rdata,
  input wire odc_chan_t [NCH-1:0] o_chan,
  input wire logic                o_clear_mode,
  input wire logic                o_por_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  logic [4:0] pins_q;
  logic [4:0] fell;
  logic [3:0] sh_q;
  logic [3:0] ld_q;
  logic [3:0] cl_q;

  assign fell = pins_q & ~i_pins;

  // cycles since a raw pin fell, saturating so it never wraps
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pins_q <= 5'h13;
      sh_q   <= 4'hf;
      ld_q   <= 4'hf;
      cl_q   <= 4'hf;
    end
    else
    begin
      pins_q <= i_pins;
      sh_q   <= fell[3] ? 4'h0 : sh_q + {3'h0, sh_q != 4'hf};
      ld_q   <= fell[1] ? 4'h0 : ld_q + {3'h0, ld_q != 4'hf};
      cl_q   <= fell[0] ? 4'h0 : cl_q + {3'h0, cl_q != 4'hf};
    end
  end

  sequence por_hold_s;
    o_por_busy [*8];
  endsequence

  por_hold_a: assert property ($rose(i_resetn) |-> por_hold_s)
    else $error("hold ended early");
  chan_reset_a: assert property ($rose(i_resetn) |-> o_chan == '0)
    else $error("channels not zero after reset");
  chan_cause_a: assert property (!$stable(o_chan) |-> sh_q < 4'h8 || ld_q < 4'h8 || cl_q < 4'h8)
    else $error("channel changed without a pin event");
  clear_code_a: assert property ($rose(o_clear_mode) |-> o_chan[0].code == o_chan[7].code
    && o_chan[3].code inside {16'h0000, 16'h8000, 16'hffff}) else $error("bad clear code");
  clear_cause_a: assert property ($rose(o_clear_mode) |-> cl_q < 4'h8)
    else $error("clear mode without clear pin");
  clear_exit_a: assert property ($fell(o_clear_mode) |-> sh_q < 4'h8)
    else $error("clear mode left outside a frame");
  por_ignore_a: assert property (o_por_busy && $past(o_por_busy) |-> !$rose(o_clear_mode))
    else $error("clear acted during hold");
  pd_keep_a: assert property (o_chan[0].pd_mode != 2'h0 && $changed(o_chan[0].pd_mode)
    |-> $stable(o_chan[0].code)) else $error("code changed on power down");
endmodule

bind odc_core odc_core_props u_props (
  .i_clock, .i_resetn, .i_clk_en, .i_pins, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
  .i_reg_rd, .o_reg_rdata, .o_chan, .o_clear_mode, .o_por_busy
);

// [odc_host.sv]
// host serial master model: frame select, shift clock and data
// frames are sent msb first by a task the bench calls
`timescale 1ns/1ps

module odc_host (
  output logic o_frame_n,
  output logic o_shift_clk,
  output logic o_data
);
  initial
  begin
    o_frame_n   = 1'b1;
    o_shift_clk = 1'b0;
    o_data      = 1'b0;
  end

  // fewer than 32 bits gives a cut-short frame
  task automatic send(input logic [31:0] word, input int nbits);
    o_frame_n = 1'b0;
    #62.5;
    for (int i = 0; i < nbits; i++)
    begin
      o_shift_clk = 1'b1;
      o_data      = word[31-i];
      #62.5;
      o_shift_clk = 1'b0;
      #62.5;
    end
    // released data line must not keep the last bit
    o_data    = ~o_data;
    o_frame_n = 1'b1;
    #20;
  endtask
endmodule

// [odc_pkg.sv]
// constants and carrier types of the octal converter serial command block
// shared by the core module and the verification side
package odc_pkg;

  localparam int NCH = 8;
  localparam int CW  = 16;
  localparam int FW  = 32;

  // power-on reset hold time, figure in ns, count in 4 ns cycles
  localparam int CLK_PERIOD_PS = 4000;
  localparam int POR_TIME_NS   = 1000;
  localparam int POR_CYCLES    = (POR_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POR_CW        = 9;

  // frame field positions
  localparam int CMD_LSB  = 24;
  localparam int ADDR_LSB = 20;
  localparam int DATA_LSB = 4;
  localparam int PD_LSB   = 8;
  localparam int MASK_LSB = 0;
  localparam int CSEL_LSB = 0;
  localparam logic [4:0] LAST_BIT = 5'h1f;

  localparam logic [3:0] CMD_WR_IN     = 4'h0;
  localparam logic [3:0] CMD_UPD_DAC   = 4'h1;
  localparam logic [3:0] CMD_WR_UPDALL = 4'h2;
  localparam logic [3:0] CMD_WR_UPD    = 4'h3;
  localparam logic [3:0] CMD_PWR       = 4'h4;
  localparam logic [3:0] CMD_CLR_CODE  = 4'h5;
  localparam logic [3:0] CMD_OVERRIDE  = 4'h6;
  localparam logic [3:0] CMD_SW_RESET  = 4'h7;
  localparam logic [3:0] ADDR_ALL      = 4'hf;

  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K     = 2'h1;
  localparam logic [1:0] PD_100K   = 2'h2;
  localparam logic [1:0] PD_OPEN   = 2'h3;

  localparam logic [1:0]  CSEL_ZERO = 2'h0;
  localparam logic [1:0]  CSEL_MID  = 2'h1;
  localparam logic [1:0]  CSEL_FULL = 2'h2;
  localparam logic [1:0]  CSEL_NOP  = 2'h3;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID  = 16'h8000;
  localparam logic [15:0] CODE_FULL = 16'hffff;

  // reset values
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [1:0]  CSEL_RST = 2'h0;
  localparam logic [7:0]  OVR_RST  = 8'h00;
  localparam logic        LINK_EN_RST = 1'b1;

  // register port offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_OVR    = 8'h08;
  localparam logic [7:0] REG_PD     = 8'h0c;
  localparam logic [7:0] REG_DAC0   = 8'h20;
  localparam logic [7:0] REG_IN0    = 8'h40;

  typedef struct packed {
    logic [1:0]  pd_mode;
    logic [15:0] code;
  } odc_chan_t;

  typedef struct packed {
    logic frame_n;
    logic shift_clk;
    logic serial_data;
    logic load_outputs_n;
    logic async_clear_n;
  } odc_pins_t;

  typedef enum logic {ST_IDLE, ST_SHIFT} odc_state_t;

endpackage
